//--- hw/led_gpo_consts.vh
`ifndef LED_GPO_CONSTS_VH
`define LED_GPO_CONSTS_VH

// register addresses
`define ADDR_GLOBAL_CFG      8'h0b
`define ADDR_INDICATOR_CTL   8'h0c
`define ADDR_PRIMARY_FAULT   8'h0d

// global configuration fields
`define GC_OUTPUT_MODE_BIT   7
`define GC_AUTO_IND_BIT      6
`define GC_FAULT_CLR_BIT     4
`define GC_FILTER_FREEZE_BIT 3
`define GC_REF_SHORT_EN_BIT  0
`define GC_WRITABLE_MASK     8'hd9
`define GC_RESET             8'h10

// indicator control fields
`define IC_WRITABLE_MASK     8'h3f
`define IC_RESET             8'h00

// primary fault summary layout
`define PF_SECONDARY_BIT     7
`define PF_THERMAL_BIT       0

// frame bit counts
`define FRAME_BITS_CRC       6'd24
`define FRAME_BITS_NOCRC     6'd16

// matrix scan: 100 us per phase at 40 MHz
`define SCAN_PHASE_NS        100000
`define SCAN_CLK_NS          25
`define SCAN_PHASE_CYCLES    (`SCAN_PHASE_NS / `SCAN_CLK_NS)

`endif

//--- hw/led_matrix_scan.v
`timescale 1ns/1ps
`default_nettype none
`include "led_gpo_consts.vh"

// drives a 2-column x 2-row open-drain indicator matrix on pins 1..5
module led_matrix_scan #(
	parameter SCAN_CYCLES = `SCAN_PHASE_CYCLES
) (
	input  wire       i_sys_clk,
	input  wire       i_rst_n,
	input  wire [3:0] i_indicators,
	output reg  [4:0] o_sink_low
);
	reg [15:0] div_q;
	reg        phase_q;
	wire       wrap;

	assign wrap = (div_q == SCAN_CYCLES - 1);

	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_q    <= 16'h0000;
			phase_q  <= 1'b0;
			o_sink_low <= 5'h00;
		end else begin
			div_q <= wrap ? 16'h0000 : div_q + 16'h0001;
			if (wrap)
				phase_q <= ~phase_q;
			// pin 5 is the shared column select, pins 1..4 sink
			o_sink_low[4] <= phase_q;
			o_sink_low[3:0] <= phase_q ?
				{i_indicators[3], 1'b0, i_indicators[2], 1'b0} :
				{1'b0, i_indicators[1], 1'b0, i_indicators[0]};
		end
	end
endmodule
`default_nettype wire

//--- hw/fault_clear_ctl.v
`timescale 1ns/1ps
`default_nettype none
`include "led_gpo_consts.vh"

// holds the primary fault flags and applies the selected clear policy
module fault_clear_ctl (
	input  wire       i_sys_clk,
	input  wire       i_rst_n,
	input  wire       i_fault_clear_mode,
	input  wire       i_cmd_done,
	input  wire       i_cmd_ok,
	input  wire       i_primary_read,
	input  wire [6:0] i_fault_set,
	input  wire       i_secondary_summary,
	output wire [7:0] o_primary_fault
);
	reg  [6:0] flag_q;
	reg  [6:0] flag_d;
	reg  [6:0] clr;

	always @* begin
		clr = 7'h00;
		if (i_fault_clear_mode) begin
			if (i_primary_read)
				clr = 7'h7f;
		end else if (i_cmd_done && i_cmd_ok) begin
			clr = 7'h7e;
		end
		// set wins over clear
		flag_d = (flag_q & ~clr) | i_fault_set;
	end

	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			flag_q <= 7'h00;
		else
			flag_q <= flag_d;
	end

	// summary tracks the unmasked secondary bits directly
	assign o_primary_fault = {i_secondary_summary, flag_q};
endmodule
`default_nettype wire

//--- hw/led_gpo_global_config.v
`timescale 1ns/1ps
`default_nettype none
`include "led_gpo_consts.vh"

// Function
// - mode 0: pins 1..5 open-drain matrix
// - mode 1: six push-pull outputs follow register
// - manual select: matrix shows indicator bits
// - autonomous select: indicators track inputs 1..4
// - clear mode 0: good command clears, not thermal
// - secondary summary clears when unmasked bits clear
// - clear mode 1: only primary read clears
// - freeze bit holds filters at mid-scale
// - bit 0 enables reference short detection
// - bit 5 drives pin 6 in mode 1
// - bit 4 drives pin 5 in mode 1
// - bits 3..0 indicators or pin levels
// - summary is OR of unmasked secondary bits
// - wrong clock count command is ignored
// - disabled detection holds reference short flag
module led_gpo_global_config (
	input  wire       i_sys_clk,
	input  wire       i_rst_n,
	input  wire       i_cmd_done,
	input  wire [5:0] i_cmd_bit_count,
	input  wire       i_crc_enable,
	input  wire       i_crc_ok,
	input  wire       i_cmd_write,
	input  wire [7:0] i_cmd_addr,
	input  wire [7:0] i_cmd_wdata,
	output reg  [7:0] o_cmd_rdata,
	input  wire [3:0] i_input_status,
	input  wire [6:0] i_primary_fault_set,
	input  wire [4:0] i_secondary_fault,
	input  wire [4:0] i_secondary_mask,
	input  wire       i_ref_short_detect,
	output reg        o_ref_short_flag,
	output wire       o_ref_short_detect_enable,
	output wire       o_filter_freeze_midscale,
	output wire [7:0] o_primary_fault,
	output reg  [5:0] o_pin_out,
	output reg  [5:0] o_pin_oe_n
);
	reg  [7:0] global_configuration_q;
	reg  [7:0] indicator_output_control_q;
	reg  [3:0] status_s1_q;
	reg  [3:0] status_s2_q;
	reg        short_s1_q;
	reg        short_s2_q;
	wire       cmd_ok;
	wire       wr_good;
	wire       output_mode_select;
	wire       autonomous_indicator_select;
	wire [3:0] indicators;
	wire [4:0] sink_low;
	wire       secondary_summary;

	function frame_len_ok;
		input [5:0] count;
		input       crc_on;
		begin
			frame_len_ok = crc_on ? (count == `FRAME_BITS_CRC) :
				(count == `FRAME_BITS_NOCRC);
		end
	endfunction

	// address match, shared by write decode and read-clear decode
	function addr_is;
		input [7:0] addr;
		input [7:0] target;
		begin
			addr_is = (addr == target);
		end
	endfunction

	// a frame with a wrong bit count or bad crc counts as no command
	assign cmd_ok = frame_len_ok(i_cmd_bit_count, i_crc_enable) &&
		(!i_crc_enable || i_crc_ok);
	assign wr_good = i_cmd_done && cmd_ok && i_cmd_write;

	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			global_configuration_q     <= `GC_RESET;
			indicator_output_control_q <= `IC_RESET;
		end else if (wr_good) begin
			if (addr_is(i_cmd_addr, `ADDR_GLOBAL_CFG))
				global_configuration_q <=
					i_cmd_wdata & `GC_WRITABLE_MASK;
			if (addr_is(i_cmd_addr, `ADDR_INDICATOR_CTL))
				indicator_output_control_q <=
					i_cmd_wdata & `IC_WRITABLE_MASK;
		end
	end

	assign output_mode_select =
		global_configuration_q[`GC_OUTPUT_MODE_BIT];
	assign autonomous_indicator_select =
		global_configuration_q[`GC_AUTO_IND_BIT];
	assign o_filter_freeze_midscale =
		global_configuration_q[`GC_FILTER_FREEZE_BIT];
	assign o_ref_short_detect_enable =
		global_configuration_q[`GC_REF_SHORT_EN_BIT];

	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status_s1_q <= 4'h0;
			status_s2_q <= 4'h0;
			short_s1_q  <= 1'b0;
			short_s2_q  <= 1'b0;
		end else begin
			status_s1_q <= i_input_status;
			status_s2_q <= status_s1_q;
			short_s1_q  <= i_ref_short_detect;
			short_s2_q  <= short_s1_q;
		end
	end

	// reference short flag: follows the synchronized detect input, frozen while detection is off
	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_ref_short_flag <= 1'b0;
		else if (o_ref_short_detect_enable)
			o_ref_short_flag <= short_s2_q;
	end

	assign indicators = autonomous_indicator_select ?
		status_s2_q :
		indicator_output_control_q[3:0];

	led_matrix_scan u_scan (
		.i_sys_clk    (i_sys_clk),
		.i_rst_n      (i_rst_n),
		.i_indicators (indicators),
		.o_sink_low   (sink_low)
	);

	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pin_out  <= 6'h00;
			o_pin_oe_n <= 6'h3f;
		end else if (output_mode_select) begin
			o_pin_out  <= indicator_output_control_q[5:0];
			o_pin_oe_n <= 6'h00;
		end else begin
			// open drain: enable only when sinking
			o_pin_out  <= 6'h00;
			o_pin_oe_n <= {1'b1, ~sink_low};
		end
	end

	assign secondary_summary =
		|(i_secondary_fault & ~i_secondary_mask);

	fault_clear_ctl u_fault (
		.i_sys_clk           (i_sys_clk),
		.i_rst_n             (i_rst_n),
		.i_fault_clear_mode  (global_configuration_q[`GC_FAULT_CLR_BIT]),
		.i_cmd_done          (i_cmd_done),
		.i_cmd_ok            (cmd_ok),
		.i_primary_read      (i_cmd_done && cmd_ok && !i_cmd_write &&
			addr_is(i_cmd_addr, `ADDR_PRIMARY_FAULT)),
		.i_fault_set         (i_primary_fault_set),
		.i_secondary_summary (secondary_summary),
		.o_primary_fault     (o_primary_fault)
	);

	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_cmd_rdata <= 8'h00;
		else begin
			case (i_cmd_addr)
			`ADDR_GLOBAL_CFG:    o_cmd_rdata <= global_configuration_q;
			`ADDR_INDICATOR_CTL: o_cmd_rdata <= indicator_output_control_q;
			`ADDR_PRIMARY_FAULT: o_cmd_rdata <= o_primary_fault;
			default:             o_cmd_rdata <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- verif/led_gpo_global_config_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module led_gpo_checker (
	input wire logic       i_sys_clk,
	input wire logic       i_rst_n,
	input wire logic       i_cmd_done,
	input wire logic [5:0] i_cmd_bit_count,
	input wire logic       i_crc_enable,
	input wire logic       i_cmd_write,
	input wire logic [7:0] i_cmd_addr,
	input wire logic [4:0] i_secondary_fault,
	input wire logic [4:0] i_secondary_mask,
	input wire logic [7:0] o_cmd_rdata,
	input wire logic       o_ref_short_flag,
	input wire logic       o_ref_short_detect_enable,
	input wire logic [7:0] o_primary_fault,
	input wire logic [5:0] o_pin_out,
	input wire logic [5:0] o_pin_oe_n
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	a_sec_summary: assert property (o_primary_fault[7] ==
		|(i_secondary_fault & ~i_secondary_mask)) else $error("summary");
	a_bad_count: assert property (i_cmd_done &&
		i_cmd_bit_count != (i_crc_enable ? 6'd24 : 6'd16)
		|=> !$fell(o_primary_fault[1])) else $error("bad frame cleared");
	a_thermal_clear: assert property ($fell(o_primary_fault[0]) |->
		$past(i_cmd_done && !i_cmd_write && i_cmd_addr == 8'h0d))
		else $error("thermal cleared");
	a_clear_cause: assert property ($fell(o_primary_fault[1])
		|-> $past(i_cmd_done)) else $error("flag cleared");
	a_ref_hold: assert property (!$past(o_ref_short_detect_enable)
		|-> $stable(o_ref_short_flag)) else $error("short flag moved");
	a_gc_reserved: assert property ($past(i_cmd_addr) == 8'h0b
		|-> (o_cmd_rdata & 8'h26) == 8'h00) else $error("gc reserved");
	a_ic_reserved: assert property ($past(i_cmd_addr) == 8'h0c
		|-> o_cmd_rdata[7:6] == 2'b00) else $error("ic reserved");
	a_enable_mirror: assert property ($past(i_cmd_addr) == 8'h0b
		|-> o_cmd_rdata[0] == $past(o_ref_short_detect_enable))
		else $error("enable bit");
	a_gpo_all: assert property (!o_pin_oe_n[5]
		|-> o_pin_oe_n == 6'h00) else $error("partial drive");
	a_open_drain: assert property (o_pin_oe_n[5] |->
		(o_pin_out[4:0] & ~o_pin_oe_n[4:0]) == 5'h00) else $error("od");
endmodule
bind led_gpo_global_config led_gpo_checker u_chk (.*);
`default_nettype wire

//--- verif/led_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module led_load_model (
	input  wire logic       i_sys_clk,
	input  wire logic [5:0] i_pin_out,
	input  wire logic [5:0] i_pin_oe_n,
	output wire logic [5:0] o_level,
	output var  logic [3:0] o_lit
);
	// released pins pulled up through the indicators
	assign o_level = (i_pin_out & ~i_pin_oe_n) | i_pin_oe_n;
	always @(posedge i_sys_clk) begin
		if (o_level[4]) begin
			o_lit[0] <= !o_level[0];
			o_lit[1] <= !o_level[2];
		end else begin
			o_lit[2] <= !o_level[1];
			o_lit[3] <= !o_level[3];
		end
	end
endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic       clk = 0, rst_n = 0, done = 0, wr = 0, crc_en = 0, crc_ok = 1;
	logic       ref_det = 0;
	logic [5:0] cnt = 6'h10;
	logic [7:0] addr = 8'h00, wdat = 8'h00;
	logic [3:0] st = 4'h0;
	logic [6:0] fset = 7'h00;
	logic [4:0] sec = 5'h00, msk = 5'h00;
	wire  [7:0] rd, pf;
	wire  [5:0] po, poe;
	wire  [3:0] lit;
	wire        rflag, ren, frz;
	int         err_count = 0, tests_run = 0;
	always #12.5 clk = ~clk;
	led_gpo_global_config u_dut (.i_sys_clk(clk), .i_rst_n(rst_n),
		.i_cmd_done(done), .i_cmd_bit_count(cnt), .i_crc_enable(crc_en),
		.i_crc_ok(crc_ok), .i_cmd_write(wr), .i_cmd_addr(addr),
		.i_cmd_wdata(wdat), .o_cmd_rdata(rd), .i_input_status(st),
		.i_primary_fault_set(fset), .i_secondary_fault(sec),
		.i_secondary_mask(msk), .i_ref_short_detect(ref_det),
		.o_ref_short_flag(rflag), .o_ref_short_detect_enable(ren),
		.o_filter_freeze_midscale(frz), .o_primary_fault(pf),
		.o_pin_out(po), .o_pin_oe_n(poe));
	led_load_model u_load (.i_sys_clk(clk), .i_pin_out(po),
		.i_pin_oe_n(poe), .o_level(), .o_lit(lit));
	task chk(input string nm, input logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task cmd(input logic w, input logic [7:0] a, d, input logic [5:0] n);
		@(negedge clk);
		{done, wr, addr, wdat, cnt} = {1'b1, w, a, d, n};
		@(negedge clk);
		done = 0;
		@(negedge clk);
	endtask
	task s_regs;
		cmd(0, 8'h0b, 8'h00, 16);
		chk("gc_rst", rd, 8'h10);
		cmd(1, 8'h0b, 8'hff, 16);
		chk("gc", rd, 8'hd9);
		chk("frz", {7'h0, frz}, 8'h01);
		cmd(1, 8'h0c, 8'hff, 16);
		chk("ic", rd, 8'h3f);
		chk("oe", {2'h0, poe}, 8'h00);
		cmd(1, 8'h0c, 8'h21, 16);
		chk("po", {2'h0, po}, 8'h21);
		cmd(1, 8'h0c, 8'h1e, 17);
		chk("po_cnt", {2'h0, po}, 8'h21);
		crc_en = 1;
		crc_ok = 0;
		cmd(1, 8'h0c, 8'h1e, 24);
		chk("po_crc", {2'h0, po}, 8'h21);
		crc_ok = 1;
		cmd(1, 8'h0c, 8'h1e, 24);
		chk("po_ok", {2'h0, po}, 8'h1e);
		crc_en = 0;
	endtask
	task s_matrix;
		cmd(1, 8'h0b, 8'h00, 16);
		cmd(1, 8'h0c, 8'h05, 16);
		repeat (8100) @(negedge clk);
		chk("lit_reg", {4'h0, lit}, 8'h05);
		chk("pin6", {7'h0, poe[5]}, 8'h01);
		st = 4'ha;
		cmd(1, 8'h0b, 8'h40, 16);
		repeat (8100) @(negedge clk);
		chk("lit_auto", {4'h0, lit}, 8'h0a);
	endtask
	task s_faults;
		@(negedge clk);
		fset = 7'h03;
		@(negedge clk);
		fset = 7'h00;
		cmd(0, 8'h0b, 8'h00, 16);
		chk("auto", pf, 8'h01);
		cmd(1, 8'h0b, 8'h10, 16);
		fset = 7'h02;
		@(negedge clk);
		fset = 7'h00;
		cmd(0, 8'h0b, 8'h00, 16);
		chk("keep", pf, 8'h03);
		cmd(0, 8'h0d, 8'h00, 16);
		chk("rdclr", pf, 8'h00);
		sec = 5'h02;
		#1 chk("sum", pf, 8'h80);
		cmd(0, 8'h0d, 8'h00, 16);
		chk("pf_rd", rd, 8'h80);
		msk = 5'h02;
		#1 chk("mask", pf, 8'h00);
	endtask
	task s_ref;
		cmd(1, 8'h0b, 8'h01, 16);
		ref_det = 1;
		repeat (4) @(negedge clk);
		chk("short", {7'h0, rflag}, 8'h01);
		cmd(1, 8'h0b, 8'h00, 16);
		ref_det = 0;
		repeat (4) @(negedge clk);
		chk("hold", {7'h0, rflag}, 8'h01);
		chk("ren_off", {7'h0, ren}, 8'h00);
		chk("frz_off", {7'h0, frz}, 8'h00);
	endtask
	task results;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1;
		s_regs;
		s_matrix;
		s_faults;
		s_ref;
		results;
	end
endmodule
`default_nettype wire
